// ### design/timer_pkg.sv
// Register map, field layout and timing constants of the protocol timer
package timer_pkg;

  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_MODE = 6'h2A;
  localparam logic [5:0] IDX_PRESCALE = 6'h2B;
  localparam logic [5:0] IDX_RELOAD_HI = 6'h2C;
  localparam logic [5:0] IDX_RELOAD_LO = 6'h2D;
  localparam logic [5:0] IDX_COUNT_HI = 6'h2E;
  localparam logic [5:0] IDX_COUNT_LO = 6'h2F;
  localparam logic [5:0] IDX_CONTROL = 6'h0C;
  localparam logic [5:0] IDX_IRQ_STATUS = 6'h04;
  localparam logic [5:0] IDX_IRQ_MASK = 6'h05;
  localparam logic [5:0] IDX_RUN_STATUS = 6'h08;

  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [15:0] COUNT_RESET = 16'h0000;

  // Control register bits (write-only strobes)
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_STOP_BIT = 1;

  // Interrupt status bit positions
  localparam int EVT_COUNTDOWN_BIT = 0;
  localparam int EVT_RELOAD_BIT = 1;
  localparam int EVT_W = 2;

  // Gate source encodings
  localparam logic [1:0] GATE_NONE = 2'h0;
  localparam logic [1:0] GATE_SERIAL_IN = 2'h1;
  localparam logic [1:0] GATE_AUXILIARY = 2'h2;
  localparam logic [1:0] GATE_ADDR_THREE = 2'h3;

  // Base tick rate derived from the bus clock, in units of 10 kHz
  localparam int BASE_FREQ_KHZ10 = 678;
  localparam int PCLK_FREQ_KHZ10 = 12500;
  localparam int BASE_ACC_W = 14;

  // Mode register layout, bit 7 down to bit 0
  typedef struct packed {
    logic protocol_start_enable;
    logic [1:0] gate_source_select;
    logic auto_reload_enable;
    logic [3:0] prescale_upper_nibble;
  } mode_fields_t;

  // Protocol events from the transceiver
  typedef struct packed {
    logic tx_end;
    logic rx_first_bit;
    logic multi_receive_enable;
  } proto_events_t;

endpackage

// ### design/reader_protocol_timer.sv
// Protocol timer with prescaler, gating, auto reload and APB registers
// Operation
// - Protocol start on: a transmission end starts the timer unless a stop event comes in the same cycle.
// - Protocol start on, multi receive off: first received bit stops the timer.
// - Protocol start on, multi receive on: reception never stops the timer.
// - Writing the stop bit halts the running timer.
// - Protocol start off: transmit and receive events have no timer effect.
// - Gate field: 00 ungated, 01/10/11 gated by first, second, third pin.
// - Gated mode: running flag follows register enable, never the gate pin.
// - Auto reload on: counter reloads and keeps counting instead of stopping.
// - Auto reload off: count to zero and stop, setting countdown interrupt flag in the same cycle.
// - Prescaler is 12 bits: mode low nibble above prescale register byte.
// - Tick rate is the 6.78 MHz base divided by the prescaler.
// - 16-bit reload value over two byte registers, high byte separate.
// - Every start event loads the counter with the reload value.
// - Reload writes while running matter at the next start or, with auto reload on, at the next reload.
// - Mode, prescale and reload high registers reset to zero, all read-write.
// - Reload low byte is its own read-write register resetting to zero.
// - Current count readable as two read-only byte registers.
//
// Added by the designer: the APB register port.
`timescale 1ns/1ps

module reader_protocol_timer
  import timer_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int PRESCALE_W = 12,
  parameter int COUNT_W = 16
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Protocol events
  input wire proto_events_t proto_events,
  // Gate pins
  input wire logic gate_pin_serial_in,
  input wire logic gate_pin_auxiliary,
  input wire logic gate_pin_addr_three,
  // Status and interrupt
  output logic running_flag,
  output logic irq
);

  // Register state
  mode_fields_t mode_q;
  logic [7:0] prescale_lower_byte_q;
  logic [7:0] reload_high_byte_q;
  logic [7:0] reload_low_byte_q;
  logic [EVT_W-1:0] irq_status_q;
  logic [EVT_W-1:0] irq_mask_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic irq_q;

  // Timer state
  logic running_q;
  logic [COUNT_W-1:0] count_q;
  logic [COUNT_W-1:0] count_d;
  logic [BASE_ACC_W-1:0] base_acc_q;
  logic [PRESCALE_W-1:0] prescale_cnt_q;

  // Bus decode
  wire [5:0] reg_index = paddr[7:2];
  wire access_phase = psel & penable;
  wire bus_capture = access_phase & ~pready_q;
  wire bus_done = access_phase & pready_q;
  wire wr_done = bus_done & pwrite;
  wire rd_done = bus_done & ~pwrite;
  wire hit_mode = (reg_index == IDX_MODE);
  wire hit_prescale = (reg_index == IDX_PRESCALE);
  wire hit_reload_hi = (reg_index == IDX_RELOAD_HI);
  wire hit_reload_lo = (reg_index == IDX_RELOAD_LO);
  wire hit_count_hi = (reg_index == IDX_COUNT_HI);
  wire hit_count_lo = (reg_index == IDX_COUNT_LO);
  wire hit_control = (reg_index == IDX_CONTROL);
  wire hit_irq_status = (reg_index == IDX_IRQ_STATUS);
  wire hit_irq_mask = (reg_index == IDX_IRQ_MASK);
  wire hit_run_status = (reg_index == IDX_RUN_STATUS);
  wire addr_in_word = (paddr[1:0] == 2'h0);
  wire read_only_hit = hit_count_hi | hit_count_lo | hit_irq_status | hit_run_status;
  wire writable_hit = hit_mode | hit_prescale | hit_reload_hi | hit_reload_lo |
                      hit_control | hit_irq_mask;
  wire mapped = addr_in_word & (writable_hit | (read_only_hit & ~pwrite) |
                (hit_irq_status & pwrite));
  wire wr_ok = wr_done & mapped;
  // Write strobes
  wire wr_mode = wr_ok & hit_mode;
  wire wr_prescale = wr_ok & hit_prescale;
  wire wr_reload_hi = wr_ok & hit_reload_hi;
  wire wr_reload_lo = wr_ok & hit_reload_lo;
  wire wr_irq_mask = wr_ok & hit_irq_mask;

  // Read multiplexer
  logic [7:0] rd_byte;
  always_comb begin
    rd_byte = REG_RESET;
    if (~addr_in_word) begin
      rd_byte = REG_RESET;
    end else if (hit_mode) begin
      rd_byte = mode_q;
    end else if (hit_prescale) begin
      rd_byte = prescale_lower_byte_q;
    end else if (hit_reload_hi) begin
      rd_byte = reload_high_byte_q;
    end else if (hit_reload_lo) begin
      rd_byte = reload_low_byte_q;
    end else if (hit_count_hi) begin
      rd_byte = count_q[15:8];
    end else if (hit_count_lo) begin
      rd_byte = count_q[7:0];
    end else if (hit_irq_status) begin
      rd_byte = {6'h00, irq_status_q};
    end else if (hit_irq_mask) begin
      rd_byte = {6'h00, irq_mask_q};
    end else if (hit_run_status) begin
      rd_byte = {7'h00, running_q};
    end
  end

  // Prescaler and base tick
  wire [PRESCALE_W-1:0] prescale_divisor = {mode_q.prescale_upper_nibble,
                                            prescale_lower_byte_q};
  wire [BASE_ACC_W-1:0] base_step = BASE_ACC_W'(BASE_FREQ_KHZ10);
  wire [BASE_ACC_W-1:0] base_wrap = BASE_ACC_W'(PCLK_FREQ_KHZ10);
  wire [BASE_ACC_W-1:0] base_sum = base_acc_q + base_step;
  wire base_tick = (base_sum >= base_wrap);
  wire [BASE_ACC_W-1:0] base_acc_d = base_tick ? (base_sum - base_wrap) : base_sum;
  // Divisor zero is taken as one
  wire [PRESCALE_W-1:0] prescale_last = (prescale_divisor == '0) ? '0 :
                                        (prescale_divisor - PRESCALE_W'(1));
  wire presc_wrap = base_tick & (prescale_cnt_q >= prescale_last);
  wire timer_tick = presc_wrap;

  // Gate selection
  logic gate_open;
  always_comb begin
    gate_open = 1'b1;
    case (mode_q.gate_source_select)
      GATE_NONE: gate_open = 1'b1;
      GATE_SERIAL_IN: gate_open = gate_pin_serial_in;
      GATE_AUXILIARY: gate_open = gate_pin_auxiliary;
      GATE_ADDR_THREE: gate_open = gate_pin_addr_three;
      default: gate_open = 1'b1;
    endcase
  end

  // Start and stop events
  wire sw_start = wr_ok & hit_control & pwdata[CTRL_START_BIT];
  wire sw_stop = wr_ok & hit_control & pwdata[CTRL_STOP_BIT];
  wire auto_start = mode_q.protocol_start_enable & proto_events.tx_end;
  wire auto_stop = mode_q.protocol_start_enable & proto_events.rx_first_bit &
                   ~proto_events.multi_receive_enable;
  wire stop_event = sw_stop | auto_stop;
  // Stop wins over a start in the same cycle
  wire start_event = (sw_start | auto_start) & ~stop_event;
  wire [COUNT_W-1:0] reload_value = {reload_high_byte_q, reload_low_byte_q};

  wire count_step = running_q & gate_open & timer_tick;
  wire reach_zero = count_step & ~mode_q.auto_reload_enable &
                    (count_q <= COUNT_W'(1));
  wire reload_wrap = count_step & mode_q.auto_reload_enable &
                     (count_q == '0);

  always_comb begin
    count_d = count_q;
    if (start_event) begin
      count_d = reload_value;
    end else if (reach_zero) begin
      count_d = '0;
    end else if (reload_wrap) begin
      count_d = reload_value;
    end else if (count_step) begin
      count_d = count_q - COUNT_W'(1);
    end
  end

  wire running_d = start_event | (running_q & ~stop_event & ~reach_zero);
  wire [EVT_W-1:0] events = {reload_wrap, reach_zero};
  // Set wins over read clear
  wire status_clear = rd_done & hit_irq_status & addr_in_word;
  wire [EVT_W-1:0] status_kept = status_clear ? '0 : irq_status_q;
  wire [EVT_W-1:0] irq_status_d = status_kept | events;
  wire irq_d = |(irq_status_d & irq_mask_q);

  // Timer run state and count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      running_q <= 1'b0;
      count_q <= COUNT_RESET;
    end else begin
      running_q <= running_d;
      count_q <= count_d;
    end
  end

  // Base tick accumulator and prescaler phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      base_acc_q <= '0;
      prescale_cnt_q <= '0;
    end else begin
      base_acc_q <= base_acc_d;
      if (start_event | presc_wrap) begin
        prescale_cnt_q <= '0;
      end else if (base_tick) begin
        prescale_cnt_q <= prescale_cnt_q + PRESCALE_W'(1);
      end
    end
  end

  // Software registers
  sw_byte_reg #(
    .W(8),
    .RESET_VAL(REG_RESET)
  ) i_sw_byte_reg_mode (
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(wr_mode),
    .wr_data(pwdata[7:0]),
    .value_q(mode_q)
  );

  sw_byte_reg #(
    .W(8),
    .RESET_VAL(REG_RESET)
  ) i_sw_byte_reg_prescale (
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(wr_prescale),
    .wr_data(pwdata[7:0]),
    .value_q(prescale_lower_byte_q)
  );

  sw_byte_reg #(
    .W(8),
    .RESET_VAL(REG_RESET)
  ) i_sw_byte_reg_reload_hi (
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(wr_reload_hi),
    .wr_data(pwdata[7:0]),
    .value_q(reload_high_byte_q)
  );

  sw_byte_reg #(
    .W(8),
    .RESET_VAL(REG_RESET)
  ) i_sw_byte_reg_reload_lo (
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(wr_reload_lo),
    .wr_data(pwdata[7:0]),
    .value_q(reload_low_byte_q)
  );

  sw_byte_reg #(
    .W(EVT_W),
    .RESET_VAL('0)
  ) i_sw_byte_reg_irq_mask (
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(wr_irq_mask),
    .wr_data(pwdata[EVT_W-1:0]),
    .value_q(irq_mask_q)
  );

  // Bus answer
  wire [31:0] rd_word = pwrite ? 32'h00000000 : {24'h000000, rd_byte};
  wire pslverr_d = ~mapped;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      prdata_q <= '0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q <= bus_capture;
      if (bus_capture) begin
        prdata_q <= rd_word;
        pslverr_q <= pslverr_d;
      end
    end
  end

  // Sticky event status
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status_q <= '0;
    end else begin
      irq_status_q <= irq_status_d;
    end
  end

  // Level interrupt from unmasked status
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= irq_d;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign running_flag = running_q;
  assign irq = irq_q;

endmodule

// Software read-write register with a write strobe
module sw_byte_reg
  import timer_pkg::*;
#(
  parameter int W = 8,
  parameter logic [W-1:0] RESET_VAL = '0
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Write port
  input wire logic wr_en,
  input wire logic [W-1:0] wr_data,
  // Stored value
  output logic [W-1:0] value_q
);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      value_q <= RESET_VAL;
    end else if (wr_en) begin
      value_q <= wr_data;
    end
  end

endmodule

// ### verification/reader_protocol_timer_props.sv
// Port-level property checker for the protocol timer
`timescale 1ns/1ps
module reader_protocol_timer_props
  import timer_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  // Clock, reset and bus
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Events, pins and status
  input wire proto_events_t proto_events,
  input wire logic gate_pin_serial_in,
  input wire logic gate_pin_auxiliary,
  input wire logic gate_pin_addr_three,
  input wire logic running_flag,
  input wire logic irq
);
  logic [7:0] mode_q;
  logic mask_q;
  logic cause_q;
  wire wr_done = psel && penable && pready && pwrite;
  wire ctl_wr = wr_done && paddr[7:2] == IDX_CONTROL;
  wire tx = proto_events.tx_end;
  wire rx = proto_events.rx_first_bit;
  wire ev_none = !tx && !rx && !wr_done;
  wire rx_stop = rx && mode_q[7] && !proto_events.multi_receive_enable;
  wire [3:0] pins = {gate_pin_addr_three, gate_pin_auxiliary, gate_pin_serial_in, 1'b0};
  wire gate_shut = mode_q[6:5] != GATE_NONE && !pins[mode_q[6:5]];

  // Shadow of the mode and mask registers seen on the bus
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= 8'h00;
      mask_q <= 1'b0;
      cause_q <= 1'b0;
    end else begin
      if (wr_done && paddr[7:2] == IDX_MODE) mode_q <= pwdata[7:0];
      if (wr_done && paddr[7:2] == IDX_IRQ_MASK) mask_q <= pwdata[EVT_COUNTDOWN_BIT];
      cause_q <= (ctl_wr && pwdata[CTRL_STOP_BIT]) || rx_stop;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_ready_wait: assert property (pready |-> psel && penable && $past(psel && penable))
    else $error("pready without a wait state");
  a_proto_start: assert property (tx && mode_q[7] && !ctl_wr && !rx_stop |=> running_flag)
    else $error("transmission end did not start timer");
  a_rx_stop: assert property (rx_stop && !tx && !ctl_wr |=> !running_flag)
    else $error("first bit did not stop timer");
  a_stop_now: assert property (ctl_wr && pwdata[CTRL_STOP_BIT] && !tx |=> !running_flag)
    else $error("stop bit did not halt timer");
  a_proto_ignored: assert property (!mode_q[7] && !running_flag && !wr_done |=> !running_flag)
    else $error("timer started without command");
  a_gate_hold: assert property (running_flag && gate_shut && $past(gate_shut) &&
    $past(gate_shut, 2) && ev_none |=> running_flag)
    else $error("running flag dropped with gate shut");
  a_irq_follows: assert property ($fell(running_flag) && !cause_q && mask_q |-> ##[0:3] irq)
    else $error("no interrupt after countdown");
  a_sw_start: assert property (ctl_wr && pwdata[1:0] == 2'h1 && !rx |=> running_flag)
    else $error("start command ignored");
  a_ro_refused: assert property (pready && pwrite && paddr[7:2] == IDX_COUNT_HI |-> pslverr)
    else $error("count write not refused");

  c_irq: cover property ($rose(irq));
  c_fall: cover property ($fell(running_flag));
  c_err: cover property (pready && pslverr);
endmodule

bind reader_protocol_timer reader_protocol_timer_props #(.ADDR_W(ADDR_W)) i_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .proto_events(proto_events), .gate_pin_serial_in(gate_pin_serial_in),
  .gate_pin_auxiliary(gate_pin_auxiliary), .gate_pin_addr_three(gate_pin_addr_three),
  .running_flag(running_flag), .irq(irq));

// ### verification/reader_protocol_timer_bench.sv
// Self-checking bench for the protocol timer
`timescale 1ns/1ps
module reader_protocol_timer_bench;
  import timer_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  proto_events_t ev = '0;
  logic [3:1] pin = 3'h0;
  logic running_flag;
  logic irq;
  int bad_count = 0;
  int checked = 0;
  int seed = 97679;
  int n;
  logic [33:0] exp_q[$];
  logic [33:0] e;
  logic [5:0] rw [4] = '{IDX_MODE, IDX_PRESCALE, IDX_RELOAD_HI, IDX_RELOAD_LO};

  reader_protocol_timer i_reader_protocol_timer (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .proto_events(ev), .gate_pin_serial_in(pin[1]),
    .gate_pin_auxiliary(pin[2]), .gate_pin_addr_three(pin[3]),
    .running_flag(running_flag), .irq(irq));

  initial forever #4 pclk = ~pclk;

  task automatic results;
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] want);
    checked++;
    if (got !== want) begin
      bad_count++;
      $display("[FAIL] %0t got %h want %h", $time, got, want);
    end
  endtask

  task automatic cmpb(input logic got, input logic want);
    cmp({31'h0, got}, {31'h0, want});
  endtask

  // Bus answers are checked here against the oldest note
  always @(posedge pclk) begin
    if (pready === 1'b1) begin
      e = exp_q.pop_front();
      cmp({31'h0, pslverr}, {31'h0, e[32]});
      if (e[33]) cmp(prdata, {24'h0, e[7:0]});
    end
  end

  task automatic xfer(input logic w, input logic [5:0] idx, input logic [7:0] d,
      input logic [7:0] x, input logic err);
    logic [31:0] r;
    r = $random(seed);
    exp_q.push_back({!w, err, 24'h0, x});
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= {r[31:8], d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n == 50) bad_count++;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask

  task automatic wr(input logic [5:0] idx, input logic [7:0] d);
    xfer(1'b1, idx, d, 8'h00, 1'b0);
  endtask

  task automatic rd(input logic [5:0] idx, input logic [7:0] x);
    xfer(1'b0, idx, 8'h00, x, 1'b0);
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge pclk);
    #1;
  endtask

  task automatic pulse(input logic t, input logic r);
    @(posedge pclk);
    ev.tx_end <= t;
    ev.rx_first_bit <= r;
    @(posedge pclk);
    ev.tx_end <= 1'b0;
    ev.rx_first_bit <= 1'b0;
    tick(2);
  endtask

  // Start by command, rewrite reload mid-run, time the countdown
  task automatic timed(input logic [7:0] m, input logic [7:0] p, input logic [7:0] rl,
      input int lo, input int hi);
    int c;
    wr(IDX_MODE, m);
    wr(IDX_PRESCALE, p);
    wr(IDX_RELOAD_HI, 8'h00);
    wr(IDX_RELOAD_LO, rl);
    wr(IDX_CONTROL, 8'h01);
    wr(IDX_RELOAD_LO, 8'hFF);
    c = 3;
    while (running_flag !== 1'b0 && c < 9000) begin
      @(posedge pclk);
      c++;
    end
    cmpb(c >= lo && c <= hi, 1'b1);
    tick(3);
    cmpb(irq, 1'b1);
    rd(IDX_IRQ_STATUS, 8'h01);
    rd(IDX_COUNT_LO, 8'h00);
    tick(3);
    cmpb(irq, 1'b0);
  endtask

  initial begin
    #320000;
    bad_count++;
    results;
  end

  initial begin
    logic [31:0] r;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      r = $random(seed);
      rd(rw[i], 8'h00);
      wr(rw[i], r[7:0]);
      rd(rw[i], r[7:0]);
    end
    xfer(1'b0, 6'h3F, 8'h00, 8'h00, 1'b1);
    xfer(1'b1, IDX_COUNT_HI, 8'h55, 8'h00, 1'b1);
    $display("registers done");
    wr(IDX_IRQ_MASK, 8'h01);
    timed(8'h00, 8'h01, 8'h03, 36, 62);
    timed(8'h01, 8'h02, 8'h01, 4730, 4770);
    $display("countdown done");
    wr(IDX_MODE, 8'h10);
    wr(IDX_PRESCALE, 8'h01);
    wr(IDX_RELOAD_LO, 8'h02);
    wr(IDX_CONTROL, 8'h01);
    tick(150);
    cmpb(running_flag, 1'b1);
    rd(IDX_IRQ_STATUS, 8'h02);
    wr(IDX_CONTROL, 8'h02);
    tick(2);
    cmpb(running_flag, 1'b0);
    $display("auto reload done");
    wr(IDX_RELOAD_HI, 8'h10);
    wr(IDX_MODE, 8'h80);
    pulse(1'b1, 1'b0);
    cmpb(running_flag, 1'b1);
    rd(IDX_COUNT_HI, 8'h10);
    pulse(1'b0, 1'b1);
    cmpb(running_flag, 1'b0);
    @(posedge pclk);
    ev.multi_receive_enable <= 1'b1;
    pulse(1'b1, 1'b0);
    pulse(1'b0, 1'b1);
    cmpb(running_flag, 1'b1);
    wr(IDX_CONTROL, 8'h02);
    tick(2);
    cmpb(running_flag, 1'b0);
    @(posedge pclk);
    ev.multi_receive_enable <= 1'b0;
    wr(IDX_MODE, 8'h00);
    pulse(1'b1, 1'b0);
    cmpb(running_flag, 1'b0);
    wr(IDX_CONTROL, 8'h01);
    pulse(1'b0, 1'b1);
    cmpb(running_flag, 1'b1);
    wr(IDX_CONTROL, 8'h02);
    $display("protocol events done");
    wr(IDX_IRQ_MASK, 8'h00);
    wr(IDX_RELOAD_HI, 8'h00);
    wr(IDX_RELOAD_LO, 8'h01);
    for (int g = 1; g < 4; g++) begin
      @(posedge pclk);
      pin <= ~(3'h1 << (g - 1));
      wr(IDX_MODE, {1'b0, 2'(g), 5'h00});
      wr(IDX_PRESCALE, 8'h01);
      wr(IDX_CONTROL, 8'h01);
      tick(80);
      cmpb(running_flag, 1'b1);
      rd(IDX_COUNT_LO, 8'h01);
      @(posedge pclk);
      pin <= 3'h7;
      tick(60);
      cmpb(running_flag, 1'b0);
      cmpb(irq, 1'b0);
      rd(IDX_IRQ_STATUS, 8'h01);
    end
    $display("gating done");
    results;
  end
endmodule
